// File: src/hbmd_ctrl.sv
// Controller driving the two control inputs of a two-input H-bridge driver
`default_nettype none
module hbmd_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User command
  input wire hbmd_pkg::hbmd_mode_t modeReq,
  input wire logic [1:0] schemeReq,
  input wire logic [hbmd_pkg::CNT_W-1:0] periodReq,
  input wire logic [hbmd_pkg::CNT_W-1:0] dutyReq,
  // Fault pin from the bridge side (asynchronous)
  input wire logic faultPin,
  // Bridge control pins
  output logic firstControlInput,
  output logic secondControlInput,
  // Status
  output logic faultSeen,
  output logic periodClamped
);
  import hbmd_pkg::*;

  // ==========================================================================
  // Reset release
  logic [1:0] rstSync_ff;   // Two-stage reset release
  logic rstSync_n;          // Synchronised reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_ff <= SYNC_RST;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_ff[1];

  // ==========================================================================
  // Fault pin synchroniser, change accepted when stages two and three agree
  logic [2:0] faultSync_ff;  // Three-stage pin capture
  logic faultLvl_ff;         // Accepted fault level
  logic nxt_faultLvl;
  assign nxt_faultLvl = (faultSync_ff[1] == faultSync_ff[2]) ? faultSync_ff[2] : faultLvl_ff;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      faultSync_ff <= PIN_SYNC_RST;
      faultLvl_ff <= 1'b0;
    end else begin
      faultSync_ff <= {faultSync_ff[1:0], faultPin};
      faultLvl_ff <= nxt_faultLvl;
    end
  end

  // ==========================================================================
  // Period limits for quiet operation
  logic [CNT_W-1:0] perEff;    // Clamped period
  logic [CNT_W-1:0] perLo;     // Lower bound, PER_MIN for both schemes
  logic [CNT_W-1:0] dutyEff;   // Clamped duty
  logic clampHit;              // Requested period outside range
  // Drive/brake must not go too slow; drive/stop must not go too fast
  assign perLo = PER_MIN;
  assign perEff = (periodReq > PER_MAX) ? PER_MAX :
                  (periodReq < perLo) ? perLo : periodReq;
  assign clampHit = (schemeReq == SCHEME_SLOW || schemeReq == SCHEME_FAST) &&
                    (perEff != periodReq);
  assign dutyEff = (dutyReq > perEff) ? perEff : dutyReq;

  // ==========================================================================
  // Modulation source
  logic pwmOn;  // Drive phase of modulation
  hbmd_pwm_gen u_pwm (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .period(perEff),
    .duty(dutyEff),
    .pwmOn(pwmOn)
  );

  // ==========================================================================
  // Pin level decode
  logic baseFirst;     // Steady first level
  logic baseSecond;    // Steady second level
  logic nxtFirst;
  logic nxtSecond;
  logic modActive;     // Modulating forward or reverse
  logic idleLvl;       // Level of the held input
  always_comb begin
    baseFirst = 1'b0;
    baseSecond = 1'b0;
    unique case (modeReq)
      HBMD_STOP: begin
        baseFirst = 1'b0;
        baseSecond = 1'b0;
      end
      HBMD_FORWARD: begin
        baseFirst = 1'b1;
        baseSecond = 1'b0;
      end
      HBMD_REVERSE: begin
        baseFirst = 1'b0;
        baseSecond = 1'b1;
      end
      HBMD_BRAKE: begin
        baseFirst = 1'b1;
        baseSecond = 1'b1;
      end
      default: begin
        baseFirst = 1'b0;
        baseSecond = 1'b0;
      end
    endcase
  end
  assign modActive = (schemeReq == SCHEME_SLOW || schemeReq == SCHEME_FAST) &&
                     (modeReq == HBMD_FORWARD || modeReq == HBMD_REVERSE);
  // Held input low for drive/stop, high for drive/brake
  assign idleLvl = (schemeReq == SCHEME_FAST);
  // Pulsed input: fast decay inverts the pulse so the on-phase drives the motor
  logic pulseLvl;    // Level of the pulsed input
  assign pulseLvl = idleLvl ? ~pwmOn : pwmOn;
  // Which input pulses. Slow decay pulses the input that goes high for the
  // direction; fast decay holds that one high and pulses the other low, so the
  // on-phase is forward or reverse and the off-phase brakes.
  logic pulseFirst;  // First input is the pulsed one
  assign pulseFirst = (modeReq == HBMD_FORWARD) ^ idleLvl;
  // A reported fault stops the bridge until the device recovers on its own
  assign nxtFirst = faultLvl_ff ? 1'b0 :
                    !modActive ? baseFirst :
                    pulseFirst ? pulseLvl : idleLvl;
  assign nxtSecond = faultLvl_ff ? 1'b0 :
                     !modActive ? baseSecond :
                     !pulseFirst ? pulseLvl : idleLvl;

  // ==========================================================================
  // Output registers; the bridge reacts to these levels directly
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      firstControlInput <= 1'b0;
      secondControlInput <= 1'b0;
      faultSeen <= 1'b0;
      periodClamped <= 1'b0;
    end else begin
      firstControlInput <= nxtFirst;
      secondControlInput <= nxtSecond;
      faultSeen <= faultLvl_ff;
      periodClamped <= clampHit;
    end
  end

  // ==========================================================================
  // Checks
  // Steady decode follows the mode one cycle later
  AST_STOP: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_STOP && !faultLvl_ff) |=> (!firstControlInput && !secondControlInput))
    else $error("stop mode did not release both inputs");
  AST_FWD: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_FORWARD && schemeReq == SCHEME_NONE && !faultLvl_ff)
    |=> (firstControlInput && !secondControlInput))
    else $error("forward levels wrong");
  AST_REV: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_REVERSE && schemeReq == SCHEME_NONE && !faultLvl_ff)
    |=> (!firstControlInput && secondControlInput))
    else $error("reverse levels wrong");
  AST_BRAKE: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_BRAKE && schemeReq == SCHEME_NONE && !faultLvl_ff)
    |=> (firstControlInput && secondControlInput))
    else $error("brake levels wrong");
  AST_SLOW_HOLD: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_FORWARD && schemeReq == SCHEME_SLOW && !faultLvl_ff)
    |=> (!secondControlInput && firstControlInput == $past(pwmOn)))
    else $error("slow decay held input not low");
  // Fast decay in reverse holds the second input high and pulses the first
  AST_FAST_HOLD: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_REVERSE && schemeReq == SCHEME_FAST && !faultLvl_ff)
    |=> (secondControlInput && firstControlInput == !$past(pwmOn)))
    else $error("fast decay held input not high");
  AST_PERIOD: assert property (@(posedge clk) disable iff (!rstSync_n)
    (perEff >= PER_MIN && perEff <= PER_MAX))
    else $error("modulation period outside quiet range");
  // Fault blanks the bridge and recovery restores the mode
  AST_FAULT: assert property (@(posedge clk) disable iff (!rstSync_n)
    faultLvl_ff |=> (!firstControlInput && !secondControlInput && faultSeen))
    else $error("fault did not stop bridge");
  AST_RECOVER: assert property (@(posedge clk) disable iff (!rstSync_n)
    ($fell(faultLvl_ff) && modeReq == HBMD_BRAKE && schemeReq == SCHEME_NONE)
    |=> (firstControlInput && secondControlInput))
    else $error("no recovery after fault cleared");
  // Modulated levels in the other direction of each scheme
  AST_SLOW_REV: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_REVERSE && schemeReq == SCHEME_SLOW && !faultLvl_ff)
    |=> (!firstControlInput && secondControlInput == $past(pwmOn)))
    else $error("slow decay reverse levels wrong");
  AST_FAST_FWD: assert property (@(posedge clk) disable iff (!rstSync_n)
    (modeReq == HBMD_FORWARD && schemeReq == SCHEME_FAST && !faultLvl_ff)
    |=> (firstControlInput && secondControlInput == !$past(pwmOn)))
    else $error("fast decay forward levels wrong");
  // Out-of-range request while modulating raises the flag a cycle later
  AST_CLAMP_FLAG: assert property (@(posedge clk) disable iff (!rstSync_n)
    ((schemeReq == SCHEME_SLOW || schemeReq == SCHEME_FAST) &&
     (periodReq < PER_MIN || periodReq > PER_MAX)) |=> periodClamped)
    else $error("out of range period not flagged");
  // Steady levels never raise the flag
  AST_CLAMP_IDLE: assert property (@(posedge clk) disable iff (!rstSync_n)
    (schemeReq == SCHEME_NONE) |=> !periodClamped)
    else $error("period flag raised without modulation");
  // An illegal mode code leaves both inputs low
  AST_ILLEGAL: assert property (@(posedge clk) disable iff (!rstSync_n)
    (!$onehot(modeReq) && !faultLvl_ff) |=> (!firstControlInput && !secondControlInput))
    else $error("illegal mode did not stop bridge");
endmodule
`default_nettype wire

// File: src/hbmd_pkg.sv
// Package of modes, encodings and timing constants for the H-bridge motor controller
`default_nettype none
package hbmd_pkg;
  // ==========================================================================
  // Command modes presented by the user side
  typedef enum logic [3:0] {
    HBMD_STOP    = 4'b0001,
    HBMD_FORWARD = 4'b0010,
    HBMD_REVERSE = 4'b0100,
    HBMD_BRAKE   = 4'b1000
  } hbmd_mode_t;

  // Speed schemes while modulating
  localparam logic [1:0] SCHEME_NONE = 2'h0;   // Steady levels, no modulation
  localparam logic [1:0] SCHEME_SLOW = 2'h1;   // Drive/stop, idle input held low
  localparam logic [1:0] SCHEME_FAST = 2'h2;   // Drive/brake, idle input held high

  // ==========================================================================
  // Clock and modulation timing
  localparam int CLK_HZ = 10_000_000;           // System clock rate
  localparam int PWM_MIN_HZ = 10_000;           // Lowest quiet modulation rate
  localparam int PWM_MAX_HZ = 50_000;           // Highest quiet modulation rate
  // Longest period in cycles (rounded down) and shortest (rounded up)
  localparam int PER_MAX_CYC = CLK_HZ / PWM_MIN_HZ;
  localparam int PER_MIN_CYC = (CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ;
  localparam int CNT_W = 10;                    // Width of period counter
  localparam logic [CNT_W-1:0] PER_MAX = CNT_W'(PER_MAX_CYC);
  localparam logic [CNT_W-1:0] PER_MIN = CNT_W'(PER_MIN_CYC);
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000; // Counter after reset
  localparam logic [1:0] SYNC_RST = 2'h0;       // Reset synchroniser value
  localparam logic [2:0] PIN_SYNC_RST = 3'h0;   // Pin synchroniser value
endpackage
`default_nettype wire

// File: src/hbmd_pwm_gen.sv
// Period and duty generator for the motor modulation
`default_nettype none
module hbmd_pwm_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // Period and duty
  input wire logic [hbmd_pkg::CNT_W-1:0] period,
  input wire logic [hbmd_pkg::CNT_W-1:0] duty,
  // Modulation output
  output logic pwmOn
);
  import hbmd_pkg::*;

  // ==========================================================================
  // Counter
  logic [CNT_W-1:0] cnt_ff;     // Position in period
  logic [CNT_W-1:0] nxt_cnt;    // Next position
  logic wrap;                   // Last cycle of period
  logic on_ff;                  // Registered drive phase
  assign wrap = (cnt_ff >= period - 10'h001);
  assign nxt_cnt = wrap ? CNT_RST : cnt_ff + 10'h001;

  // Count through each period
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cnt_ff <= CNT_RST;
      on_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      on_ff <= (nxt_cnt < duty);
    end
  end
  assign pwmOn = on_ff;
endmodule
`default_nettype wire

// File: tb/hbmd_bridge_model.sv
// Behavioural model of the two-input H-bridge driver seen by the controller
`default_nettype none
module hbmd_bridge_model (
  // Control pins from the controller
  input wire logic firstControlInput,
  input wire logic secondControlInput,
  // Protection stimulus from the bench
  input wire logic overcurrentGuard,
  input wire logic overTemp,
  // Bridge outputs and fault report
  output wire logic firstBridgeOutput,
  output wire logic secondBridgeOutput,
  output wire logic faultOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Protection lasts only while its cause does, so recovery needs no action
  wire logic guardOn = overcurrentGuard | overTemp;
  // Both inputs low switches every transistor off
  wire logic stopOn = !firstControlInput && !secondControlInput;
  // Outputs follow present levels; brake pulls both low
  assign firstBridgeOutput = (stopOn || guardOn) ? 1'bz :
    (firstControlInput && !secondControlInput);
  assign secondBridgeOutput = (stopOn || guardOn) ? 1'bz :
    (secondControlInput && !firstControlInput);
  assign faultOut = guardOn;
endmodule
`default_nettype wire

// File: tb/tb_hbmd_ctrl.sv
// Self-checking testbench of the H-bridge motor controller
`default_nettype none
module tb_hbmd_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import hbmd_pkg::*;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  hbmd_mode_t modeReq = HBMD_STOP;
  logic [1:0] schemeReq = SCHEME_NONE;
  logic [9:0] periodReq = 10'h0c8;
  logic [9:0] dutyReq = 10'h064;
  logic overcurrentGuard = 1'b0;
  logic overTemp = 1'b0;
  wire logic faultPin, firstControlInput, secondControlInput, faultSeen, periodClamped;
  wire logic firstBridgeOutput, secondBridgeOutput;
  int errors = 0;
  int checks = 0;
  int hi1, hi2;
  always #50 clk = ~clk;
  hbmd_ctrl i_dut (.clk(clk), .arst_n(arst_n), .modeReq(modeReq), .schemeReq(schemeReq),
    .periodReq(periodReq), .dutyReq(dutyReq), .faultPin(faultPin),
    .firstControlInput(firstControlInput), .secondControlInput(secondControlInput),
    .faultSeen(faultSeen), .periodClamped(periodClamped));
  hbmd_bridge_model i_bridge (.firstControlInput(firstControlInput),
    .secondControlInput(secondControlInput), .overcurrentGuard(overcurrentGuard),
    .overTemp(overTemp), .firstBridgeOutput(firstBridgeOutput),
    .secondBridgeOutput(secondBridgeOutput), .faultOut(faultPin));
  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] expv);
    checks++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, expv, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Apply a command, let it settle, then count high cycles of both pins
  task automatic runReq(input logic [3:0] m, input logic [1:0] s, input logic [9:0] p,
      input logic [9:0] d, input int settle, input int span);
    modeReq = hbmd_mode_t'(m);
    schemeReq = s;
    periodReq = p;
    dutyReq = d;
    cycles(settle);
    hi1 = 0;
    hi2 = 0;
    repeat (span) begin
      @(negedge clk);
      hi1 += (firstControlInput === 1'b1);
      hi2 += (secondControlInput === 1'b1);
    end
  endtask
  // Bounded wait for the accepted fault level
  task automatic waitFault(input logic lvl);
    int n;
    n = 0;
    while (faultSeen !== lvl && n < 20) begin
      cycles(1);
      n++;
    end
    check("faultSeen", faultSeen, lvl);
    if (faultSeen !== lvl) give_verdict();
  endtask
  // ==========================================
  // Scenarios
  task automatic steadyModes();
    logic [3:0] m [5] = '{4'b0001, 4'b0010, 4'b0100, 4'b1000, 4'b0011};
    logic [1:0] pins [5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00};
    logic [1:0] outs [5] = '{2'bzz, 2'b10, 2'b01, 2'b00, 2'bzz};
    for (int i = 0; i < 5; i++) begin
      runReq(m[i], SCHEME_NONE, 10'h0c8, 10'h064, 2, 0);
      check("pins", {firstControlInput, secondControlInput}, pins[i]);
      check("bridge", {firstBridgeOutput, secondBridgeOutput}, outs[i]);
    end
  endtask
  task automatic decaySchemes();
    runReq(4'b0010, SCHEME_SLOW, 10'h0c8, 10'h064, 400, 400);
    check("slowFwd", 10'(hi1 * 4 + hi2), 10'h320);
    runReq(4'b0100, SCHEME_SLOW, 10'h0c8, 10'h064, 400, 400);
    check("slowRev", 10'(hi1 * 4 + hi2), 10'h0c8);
    runReq(4'b0010, SCHEME_FAST, 10'h0c8, 10'h032, 400, 400);
    check("fastFwd", 10'(hi2), 10'h12c);
    check("fastIdle", 10'(hi1), 10'h190);
    runReq(4'b0100, SCHEME_FAST, 10'h0c8, 10'h032, 400, 400);
    check("fastRev", 10'(hi1), 10'h12c);
    check("fastRevIdle", 10'(hi2), 10'h190);
  endtask
  task automatic periodLimits();
    runReq(4'b0010, SCHEME_SLOW, 10'h064, 10'h064, 1100, 400);
    check("lowClamp", 10'(hi1), 10'h0c8);
    check("clampFlag", periodClamped, 10'h001);
    runReq(4'b0010, SCHEME_SLOW, 10'h3ff, 10'h1f4, 1100, 1000);
    check("highClamp", 10'(hi1), 10'h1f4);
    check("clampFlagHi", periodClamped, 10'h001);
    runReq(4'b0010, SCHEME_SLOW, 10'h0c8, 10'h064, 1100, 0);
    check("inRange", periodClamped, 10'h000);
  endtask
  // Over-current recovers into forward, over-temperature into brake
  task automatic faultRecover(input bit thermal);
    logic [3:0] m;
    logic [9:0] pinsExp;
    m = thermal ? 4'b1000 : 4'b0010;
    pinsExp = thermal ? 10'h003 : 10'h002;
    runReq(m, SCHEME_NONE, 10'h0c8, 10'h064, 4, 0);
    if (thermal) overTemp = 1'b1;
    else overcurrentGuard = 1'b1;
    waitFault(1'b1);
    cycles(2);
    check("pinsInFault", {firstControlInput, secondControlInput}, 10'h000);
    overTemp = 1'b0;
    overcurrentGuard = 1'b0;
    waitFault(1'b0);
    cycles(2);
    check("pinsAfter", {firstControlInput, secondControlInput}, pinsExp);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    cycles(2);
    arst_n = 1'b1;
    cycles(3);
    steadyModes();
    decaySchemes();
    periodLimits();
    faultRecover(1'b0);
    faultRecover(1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
